// File: design/crr_loc_mem.sv
// Two-bank peak location store with byte-lane writes and registered read
`timescale 1ns/100ps
module crr_loc_mem (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [1:0] wbe,
  input wire logic [crr_pkg::MEM_AW-1:0] waddr,
  input wire logic [crr_pkg::REG_W-1:0] wdata,
  // Read side
  input wire logic [crr_pkg::MEM_AW-1:0] raddr,
  output logic [crr_pkg::REG_W-1:0] rdata
);

  logic [crr_pkg::REG_W-1:0] mem [crr_pkg::MEM_WORDS];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset: stale words are masked by the valid bits upstream
  always_ff @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (we && wbe[b]) begin
        mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
    rdata <= mem[raddr];
  end

endmodule

// File: design/crr_pkg.sv
// Constants, layouts and types shared by the reflectometry result block
package crr_pkg;

  // ----------------------------------------------------------------
  // Geometry of the results
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int PEAKS_PER_CHAN = 5;
  localparam int NUM_ENTRIES = 20;
  localparam int LOC_W = 8;
  localparam int REG_W = 16;
  localparam logic [2:0] PEAK_MAX = 3'h5;
  localparam logic [2:0] PEAK_LAST = 3'h4;

  // ----------------------------------------------------------------
  // Bus widths and register indices (byte address is index times 4)
  // ----------------------------------------------------------------
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_LOC_FIRST = 10'h190;
  localparam logic [9:0] IDX_LOC_LAST = 10'h199;
  localparam logic [9:0] IDX_GEN_STATUS = 10'h1a4;
  localparam logic [9:0] IDX_SIGN_AB = 10'h1a5;
  localparam logic [9:0] IDX_SIGN_CD = 10'h1a6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CROSS_LSB = 8;
  localparam int OVF_LSB = 4;
  localparam int SEG1_LSB = 0;
  localparam int STATUS_RSV_LSB = 12;
  localparam int SIGN_USED_W = 10;
  localparam int SIGN_HI_LSB = 5;
  localparam int LOC_HI_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GEN_STATUS_RST = 16'h0000;
  localparam logic [15:0] SIGN_AB_RST = 16'h0000;
  localparam logic [15:0] SIGN_CD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Bus responses and location memory shape
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int MEM_AW = 5;
  localparam int MEM_WORDS = 32;

  // Read channel states, Gray coded along idle-fetch-load-resp
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_LOAD = 2'b11,
    RD_RESP = 2'b10
  } crr_rd_state_t;

endpackage

// File: design/crr_top.sv
// Reflectometry result registers with AXI4-Lite read-only access
`timescale 1ns/100ps
// What this block does
// - A cross-mode peak on channel A..D sets status bit 8..11.
// - Reaching five peaks in the segment sets overflow bit 4..7 for A..D.
// - A peak above the segment-one high threshold sets bit 0..3 for A..D.
// - Peak signs 0..4 of A sit in bits 4..0 and of B in 9..5 of sign ab.
// - Peak signs 0..4 of C sit in bits 4..0 and of D in 9..5 of sign cd.
// - Bits 15 to 10 of both sign registers read as zero.
// - The sign register for A and B sits at index 0x1a5, read-only, reset 0.
// - The sign register for C and D sits at index 0x1a6, read-only, reset 0.
// - The general status register sits at index 0x1a4, read-only, reset 0.
// - Peak locations are 8-bit fields, two per register, five per channel.
module crr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [crr_pkg::AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [crr_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [crr_pkg::AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [crr_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  // Measurement engine
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic peak_valid,
  input wire logic [1:0] peak_chan,
  input wire logic [crr_pkg::LOC_W-1:0] peak_loc,
  input wire logic peak_sign,
  input wire logic peak_cross,
  input wire logic peak_seg1_high
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [crr_pkg::IDX_W-1:0] idx);
    is_mapped = (idx >= crr_pkg::IDX_LOC_FIRST &&
                 idx <= crr_pkg::IDX_LOC_LAST) ||
                idx == crr_pkg::IDX_GEN_STATUS ||
                idx == crr_pkg::IDX_SIGN_AB ||
                idx == crr_pkg::IDX_SIGN_CD;
  endfunction

  function automatic logic [4:0] entry_of(input logic [1:0] chan,
                                          input logic [2:0] cnt);
    entry_of = {3'h0, chan} * 5'h05 + {2'h0, cnt};
  endfunction

  // ----------------------------------------------------------------
  // Measurement shadow state
  // ----------------------------------------------------------------
  logic [3:0][2:0] cnt_r;
  logic [3:0][2:0] cnt_base;
  logic [3:0][2:0] cnt_nxt;
  logic [3:0] cross_r, cross_base, cross_nxt;
  logic [3:0] ovf_r, ovf_base, ovf_nxt;
  logic [3:0] seg_r, seg_base, seg_nxt;
  logic [3:0] take;
  logic [crr_pkg::NUM_ENTRIES-1:0] sign_sh_r, sign_sh_nxt;
  logic [crr_pkg::NUM_ENTRIES-1:0] vld_sh_r, vld_sh_nxt;

  // Committed results seen by software
  logic [crr_pkg::REG_W-1:0] gen_status_r;
  logic [crr_pkg::REG_W-1:0] sign_ab_r;
  logic [crr_pkg::REG_W-1:0] sign_cd_r;
  logic [crr_pkg::NUM_ENTRIES-1:0] loc_valid_r;
  logic bank_r;
  wire [crr_pkg::REG_W-1:0] gen_status_nxt;

  // Per channel: a start wipes the shadow, peaks then accumulate
  for (genvar c = 0; c < crr_pkg::NUM_CHAN; c++) begin : g_chan
    wire hit = peak_valid && peak_chan == 2'(c);
    assign cnt_base[c] = meas_start ? 3'h0 : cnt_r[c];
    assign cross_base[c] = meas_start ? 1'b0 : cross_r[c];
    assign ovf_base[c] = meas_start ? 1'b0 : ovf_r[c];
    assign seg_base[c] = meas_start ? 1'b0 : seg_r[c];
    // Peaks past the fifth are dropped; only the cross and segment flags record them
    assign take[c] = hit && cnt_base[c] != crr_pkg::PEAK_MAX;
    assign cnt_nxt[c] = take[c] ? cnt_base[c] + 3'h1 : cnt_base[c];
    assign cross_nxt[c] = cross_base[c] | (hit & peak_cross);
    assign ovf_nxt[c] = ovf_base[c] |
        (take[c] && cnt_base[c] == crr_pkg::PEAK_LAST);
    assign seg_nxt[c] = seg_base[c] | (hit & peak_seg1_high);
    // Sign and valid bit of each of the five peak slots
    for (genvar p = 0; p < crr_pkg::PEAKS_PER_CHAN; p++) begin : g_peak
      localparam int E = c * crr_pkg::PEAKS_PER_CHAN + p;
      wire slot = take[c] && cnt_base[c] == 3'(p);
      wire sb = meas_start ? 1'b0 : sign_sh_r[E];
      wire vb = meas_start ? 1'b0 : vld_sh_r[E];
      assign sign_sh_nxt[E] = slot ? peak_sign : sb;
      assign vld_sh_nxt[E] = slot | vb;
    end
  end

  // Status word as it will be committed
  assign gen_status_nxt = {4'h0, cross_nxt, ovf_nxt, seg_nxt};

  // Shadow registers follow the engine every cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      cross_r <= 4'h0;
      ovf_r <= 4'h0;
      seg_r <= 4'h0;
      sign_sh_r <= '0;
      vld_sh_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      cross_r <= cross_nxt;
      ovf_r <= ovf_nxt;
      seg_r <= seg_nxt;
      sign_sh_r <= sign_sh_nxt;
      vld_sh_r <= vld_sh_nxt;
    end
  end

  // Commit at measurement end only, so software never sees half a run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_status_r <= crr_pkg::GEN_STATUS_RST;
      sign_ab_r <= crr_pkg::SIGN_AB_RST;
      sign_cd_r <= crr_pkg::SIGN_CD_RST;
      loc_valid_r <= '0;
      bank_r <= 1'b0;
    end else if (meas_done) begin
      gen_status_r <= gen_status_nxt;
      sign_ab_r <= {6'h00, sign_sh_nxt[9:0]};
      sign_cd_r <= {6'h00, sign_sh_nxt[19:10]};
      loc_valid_r <= vld_sh_nxt;
      bank_r <= ~bank_r;
    end
  end

  // ----------------------------------------------------------------
  // Location store: engine fills the idle bank, software reads the other
  // ----------------------------------------------------------------
  wire [4:0] wr_entry = entry_of(peak_chan, cnt_base[peak_chan]);
  wire mem_we = |take;
  wire [1:0] mem_wbe = wr_entry[0] ? 2'b10 : 2'b01;
  wire [crr_pkg::MEM_AW-1:0] mem_waddr = {~bank_r, wr_entry[4:1]};
  wire [crr_pkg::REG_W-1:0] mem_wdata = {peak_loc, peak_loc};
  logic [crr_pkg::IDX_W-1:0] rd_idx_r;
  wire [3:0] rd_word = 4'(rd_idx_r - crr_pkg::IDX_LOC_FIRST);
  wire [crr_pkg::MEM_AW-1:0] mem_raddr = {bank_r, rd_word};
  wire [crr_pkg::REG_W-1:0] mem_rdata;

  crr_loc_mem u_loc_mem (
    .clk(aclk),
    .we(mem_we),
    .wbe(mem_wbe),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire rd_is_loc = rd_idx_r >= crr_pkg::IDX_LOC_FIRST &&
                   rd_idx_r <= crr_pkg::IDX_LOC_LAST;
  // Unfound peak slots read as zero rather than stale bank data
  wire [1:0] loc_vld = loc_valid_r[{rd_word, 1'b0} +: 2];
  wire [crr_pkg::REG_W-1:0] loc_mask = {{8{loc_vld[1]}}, {8{loc_vld[0]}}};
  wire [crr_pkg::REG_W-1:0] rd_val16 =
      rd_is_loc ? (mem_rdata & loc_mask) :
      rd_idx_r == crr_pkg::IDX_GEN_STATUS ? gen_status_r :
      rd_idx_r == crr_pkg::IDX_SIGN_AB ? sign_ab_r :
      rd_idx_r == crr_pkg::IDX_SIGN_CD ? sign_cd_r :
      16'h0000;
  wire rd_ok = is_mapped(rd_idx_r);

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  crr_pkg::crr_rd_state_t rd_state_r, rd_state_nxt;
  logic arready_r, rvalid_r;
  logic [crr_pkg::AXI_DW-1:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = arvalid && arready_r;
  wire r_done = rvalid_r && rready;

  // Next state; one read in flight, so no address buffering is needed
  always_comb begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      crr_pkg::RD_IDLE: if (ar_take) rd_state_nxt = crr_pkg::RD_FETCH;
      crr_pkg::RD_FETCH: rd_state_nxt = crr_pkg::RD_LOAD;
      crr_pkg::RD_LOAD: rd_state_nxt = crr_pkg::RD_RESP;
      crr_pkg::RD_RESP: if (r_done) rd_state_nxt = crr_pkg::RD_IDLE;
      default: rd_state_nxt = crr_pkg::RD_IDLE;
    endcase
  end

  // Read registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= crr_pkg::RD_IDLE;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= crr_pkg::RESP_OKAY;
      rd_idx_r <= '0;
    end else begin
      rd_state_r <= rd_state_nxt;
      arready_r <= rd_state_nxt == crr_pkg::RD_IDLE;
      if (ar_take) rd_idx_r <= araddr[crr_pkg::AXI_AW-1:2];
      if (rd_state_r == crr_pkg::RD_LOAD) begin
        rvalid_r <= 1'b1;
        rdata_r <= {16'h0000, rd_val16};
        rresp_r <= rd_ok ? crr_pkg::RESP_OKAY : crr_pkg::RESP_SLVERR;
      end else if (r_done) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write channel: every register is read-only, writes are discarded
  // ----------------------------------------------------------------
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r;
  logic [1:0] bresp_r;
  logic [crr_pkg::IDX_W-1:0] wr_idx_r;
  wire aw_take = awvalid && awready_r;
  wire w_take = wvalid && wready_r;
  wire aw_have = aw_got_r || aw_take;
  wire w_have = w_got_r || w_take;
  wire b_fire = aw_have && w_have && !bvalid_r;
  wire b_done = bvalid_r && bready;
  wire [crr_pkg::IDX_W-1:0] wr_idx_now =
      aw_take ? awaddr[crr_pkg::AXI_AW-1:2] : wr_idx_r;
  wire aw_got_nxt = b_fire ? 1'b0 : aw_have;
  wire w_got_nxt = b_fire ? 1'b0 : w_have;
  wire bvalid_nxt = b_fire || (bvalid_r && !b_done);

  // Address and data taken in either order, answer once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= crr_pkg::RESP_OKAY;
      wr_idx_r <= '0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      bvalid_r <= bvalid_nxt;
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      if (aw_take) wr_idx_r <= wr_idx_now;
      if (b_fire) begin
        bresp_r <= is_mapped(wr_idx_now) ? crr_pkg::RESP_OKAY :
                   crr_pkg::RESP_SLVERR;
      end
    end
  end

  // Output wiring, all from flip-flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cross_flag_commit_a: assert property (
    meas_done |=> gen_status_r[11:8] == $past(cross_nxt))
    else $error("cross-mode flags not committed at measurement end");

  // Checked against the slot counters, not the flag logic it guards
  overflow_fifth_peak_a: assert property (
    meas_done |=> gen_status_r[7:4] ==
      {cnt_r[3] == crr_pkg::PEAK_MAX, cnt_r[2] == crr_pkg::PEAK_MAX,
       cnt_r[1] == crr_pkg::PEAK_MAX, cnt_r[0] == crr_pkg::PEAK_MAX})
    else $error("overflow flags disagree with peak counts");

  seg1_flag_commit_a: assert property (
    meas_done |=> gen_status_r[3:0] == $past(seg_nxt))
    else $error("segment one flags not committed");

  status_rsv_zero_a: assert property (
    rvalid_r && rd_idx_r == crr_pkg::IDX_GEN_STATUS |->
      rdata_r[31:12] == 20'h00000)
    else $error("status reserved bits not zero");

  sign_groups_map_a: assert property (
    meas_done |=> sign_ab_r[9:5] == $past(sign_sh_nxt[9:5]) &&
      sign_ab_r[4:0] == $past(sign_sh_nxt[4:0]))
    else $error("channel A or B sign bits misplaced");

  sign_cd_map_a: assert property (
    meas_done |=> sign_cd_r[9:0] == $past(sign_sh_nxt[19:10]))
    else $error("channel C or D sign bits misplaced");

  sign_rsv_zero_a: assert property (
    sign_ab_r[15:10] == 6'h00 && sign_cd_r[15:10] == 6'h00)
    else $error("sign reserved bits not zero");

  sign_ab_read_a: assert property (
    ar_take && araddr[11:2] == crr_pkg::IDX_SIGN_AB |-> ##3
      (rvalid_r && rresp_r == crr_pkg::RESP_OKAY &&
       rdata_r == {16'h0000, $past(sign_ab_r)}))
    else $error("sign ab read wrong or late");

  sign_cd_read_a: assert property (
    ar_take && araddr[11:2] == crr_pkg::IDX_SIGN_CD |-> ##3
      (rvalid_r && rdata_r == {16'h0000, $past(sign_cd_r)}))
    else $error("sign cd read wrong or late");

  status_read_a: assert property (
    ar_take && araddr[11:2] == crr_pkg::IDX_GEN_STATUS |-> ##3
      (rvalid_r && rdata_r == {16'h0000, $past(gen_status_r)}))
    else $error("status read wrong or late");

  loc_unfound_zero_a: assert property (
    rd_state_r == crr_pkg::RD_LOAD && rd_is_loc && loc_vld == 2'b00 |=>
      rdata_r == 32'h00000000)
    else $error("unfound location not read as zero");

  results_stable_a: assert property (
    !meas_done |=> $stable(gen_status_r) && $stable(sign_ab_r) &&
      $stable(sign_cd_r) && $stable(bank_r))
    else $error("results changed between measurements");

  read_status_c: cover property (
    ar_take && araddr[11:2] == crr_pkg::IDX_GEN_STATUS ##3 r_done);
  write_resp_c: cover property (b_done && bresp_r == crr_pkg::RESP_OKAY);
  overflow_seen_c: cover property (meas_done && ovf_nxt[3]);
  unmapped_read_c: cover property (r_done && rresp_r == crr_pkg::RESP_SLVERR);

endmodule

// File: verification/cable_reflectometry_results_test.sv
// Self-checking bench for the reflectometry result registers
`timescale 1ns/100ps
module cable_reflectometry_results_test;
  // ----------------------------------------------------------------
  // Bench signals and expected state
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic meas_start, meas_done, peak_valid;
  logic peak_sign, peak_cross, peak_seg1_high;
  logic [1:0] peak_chan;
  logic [7:0] peak_loc;
  int errors = 0;
  int checks_done = 0;
  logic [15:0] sh_stat, cm_stat;
  logic [9:0] sh_sign [2];
  logic [9:0] cm_sign [2];
  logic [7:0] sh_loc [20];
  logic [7:0] cm_loc [20];
  int sh_cnt [4];
  int cnt_tab [2][4] = '{'{6, 2, 1, 5}, '{0, 5, 5, 3}};
  typedef struct {
    logic [11:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
  } crr_row_t;
  crr_row_t rows [15];

  // 50 MHz clock
  always #10 aclk = ~aclk;

  crr_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .meas_start(meas_start),
    .meas_done(meas_done), .peak_valid(peak_valid), .peak_chan(peak_chan),
    .peak_loc(peak_loc), .peak_sign(peak_sign), .peak_cross(peak_cross),
    .peak_seg1_high(peak_seg1_high));

  crr_engine_model eng_u (.aclk(aclk), .meas_start(meas_start),
    .meas_done(meas_done), .peak_valid(peak_valid), .peak_chan(peak_chan),
    .peak_loc(peak_loc), .peak_sign(peak_sign), .peak_cross(peak_cross),
    .peak_seg1_high(peak_seg1_high));

  // ----------------------------------------------------------------
  // Report and compare tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic timeout_hit();
    errors++;
    $display("FAIL %0t bus wait ran out got %h exp %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // AXI4-Lite master
  // ----------------------------------------------------------------
  // Bounded waits: a stuck slave ends the run instead of hanging it
  task automatic axi_read(input logic [11:0] a, output logic [31:0] dd,
                          output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    arprot <= 3'h1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    if (arready !== 1'b1) timeout_hit();
    arvalid <= 1'b0;
    araddr <= ~a;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1) timeout_hit();
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // Lags hold back address or data so both arrival orders are exercised
  task automatic axi_write(input logic [11:0] a, input int aw_lag,
                           input int w_lag, output logic [1:0] rr);
    int n;
    logic aw_p, w_p, aw_on, w_on;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    aw_on = (aw_lag == 0);
    w_on = (w_lag == 0);
    @(posedge aclk);
    awvalid <= aw_on;
    awaddr <= a;
    awprot <= 3'h2;
    wvalid <= w_on;
    wdata <= 32'hffff_ffff;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_on && aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end else if (!aw_on && n >= aw_lag) begin
        aw_on = 1'b1;
        awvalid <= 1'b1;
      end
      if (w_on && w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end else if (!w_on && n >= w_lag) begin
        w_on = 1'b1;
        wvalid <= 1'b1;
      end
    end while ((aw_p || w_p) && n < 50);
    if (aw_p || w_p) timeout_hit();
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1) timeout_hit();
    rr = bresp;
    bready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Expected results and scenarios
  // ----------------------------------------------------------------
  // Peak k of a channel only lands in a slot while fewer than five are held
  task automatic add_peak(input int ch, input int k, input int m);
    logic [7:0] loc;
    logic c;
    loc = 8'(ch * 64 + m * 32 + k + 1);
    c = ((ch % 2) == m);
    eng_u.peak(2'(ch), loc, loc[0] ^ loc[6], c, !c);
    if (c) sh_stat[8 + ch] = 1'b1;
    else sh_stat[ch] = 1'b1;
    if (sh_cnt[ch] < 5) begin
      sh_sign[ch / 2][(ch % 2) * 5 + sh_cnt[ch]] = loc[0] ^ loc[6];
      sh_loc[ch * 5 + sh_cnt[ch]] = loc;
      sh_cnt[ch]++;
      if (sh_cnt[ch] == 5) sh_stat[4 + ch] = 1'b1;
    end
  endtask

  // Rows: address, expected word and response
  task automatic check_rows();
    for (int i = 0; i < 10; i++) begin
      rows[i] = '{12'(12'h640 + 4 * i),
                  {16'h0, cm_loc[2 * i + 1], cm_loc[2 * i]},
                  crr_pkg::RESP_OKAY};
    end
    rows[10] = '{12'h690, {16'h0, cm_stat}, crr_pkg::RESP_OKAY};
    rows[11] = '{12'h694, {22'h0, cm_sign[0]}, crr_pkg::RESP_OKAY};
    rows[12] = '{12'h698, {22'h0, cm_sign[1]}, crr_pkg::RESP_OKAY};
    rows[13] = '{12'h69c, 32'h0, crr_pkg::RESP_SLVERR};
    rows[14] = '{12'h000, 32'h0, crr_pkg::RESP_SLVERR};
    for (int i = 0; i < 15; i++) begin
      axi_read(rows[i].addr, d, r);
      check_data(d, rows[i].data);
      check_resp(r, rows[i].resp);
    end
  endtask

  // Channels interleaved; view must not move before done
  task automatic run_meas(input int m);
    eng_u.pulse(1'b0);
    sh_stat = 16'h0;
    sh_sign = '{default: 10'h0};
    sh_loc = '{default: 8'h0};
    sh_cnt = '{default: 0};
    for (int k = 0; k < 6; k++) begin
      for (int ch = 0; ch < 4; ch++) begin
        if (k < cnt_tab[m][ch]) add_peak(ch, k, m);
      end
    end
    axi_read(12'h690, d, r);
    check_data(d, {16'h0, cm_stat});
    eng_u.pulse(1'b1);
    cm_stat = sh_stat;
    cm_sign = sh_sign;
    cm_loc = sh_loc;
    check_rows();
  endtask

  // Main sequence
  initial begin
    cm_stat = 16'h0;
    cm_sign = '{default: 10'h0};
    cm_loc = '{default: 8'h0};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check_rows();
    run_meas(0);
    run_meas(1);
    axi_write(12'h690, 0, 0, r);
    check_resp(r, crr_pkg::RESP_OKAY);
    axi_write(12'h694, 0, 2, r);
    check_resp(r, crr_pkg::RESP_OKAY);
    axi_write(12'h698, 2, 0, r);
    check_resp(r, crr_pkg::RESP_OKAY);
    axi_write(12'h69c, 1, 1, r);
    check_resp(r, crr_pkg::RESP_SLVERR);
    check_rows();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cm_stat = 16'h0;
    cm_sign = '{default: 10'h0};
    cm_loc = '{default: 8'h0};
    check_rows();
    stop_test();
  end
endmodule

// File: verification/crr_engine_model.sv
// Behavioural measurement engine that feeds the result block
`timescale 1ns/100ps
module crr_engine_model (
  // Clock
  input wire logic aclk,
  // Engine outputs
  output logic meas_start,
  output logic meas_done,
  output logic peak_valid,
  output logic [1:0] peak_chan,
  output logic [crr_pkg::LOC_W-1:0] peak_loc,
  output logic peak_sign,
  output logic peak_cross,
  output logic peak_seg1_high
);
  // Quiet engine at time zero
  initial begin
    meas_start = 1'b0;
    meas_done = 1'b0;
    peak_valid = 1'b0;
    peak_chan = 2'h0;
    peak_loc = 8'h00;
    peak_sign = 1'b0;
    peak_cross = 1'b0;
    peak_seg1_high = 1'b0;
  end

  // One-cycle start or done pulse
  task automatic pulse(input logic done);
    @(posedge aclk);
    if (done) meas_done <= 1'b1;
    else meas_start <= 1'b1;
    @(posedge aclk);
    meas_done <= 1'b0;
    meas_start <= 1'b0;
  endtask

  // One peak; qualifiers turn stale after it so no one can lean on them
  task automatic peak(input logic [1:0] ch, input logic [7:0] loc,
                      input logic s, input logic c, input logic h);
    @(posedge aclk);
    peak_valid <= 1'b1;
    peak_chan <= ch;
    peak_loc <= loc;
    peak_sign <= s;
    peak_cross <= c;
    peak_seg1_high <= h;
    @(posedge aclk);
    peak_valid <= 1'b0;
    peak_chan <= ~ch;
    peak_loc <= ~loc;
    peak_sign <= ~s;
    peak_cross <= ~c;
    peak_seg1_high <= ~h;
  endtask
endmodule
